/* File: core/cgc_core.sv */
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module cgc_core (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        srst_in,
	// register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic [31:0]      reg_rdata_out,
	// oscillator ticks, one per half period
	input  wire logic        losc_tick_in,
	input  wire logic        hosc_tick_in,
	input  wire logic        main_tick_in,
	input  wire logic        sub_tick_in,
	input  wire logic        pll_tick_in,
	// event link
	input  wire logic        evt_switch_in,
	output logic             evt_stop_out,
	// oscillator and pll control
	output logic             pll_source_select_out,
	output logic [1:0]       pll_prediv_out,
	output logic [5:0]       pll_mult_out,
	output logic [1:0]       hosc_freq_out,
	output logic             hosc_power_on_out,
	// derived clocks and pins
	output logic             system_clock_out,
	output logic             adc0_conversion_clock_out,
	output logic             adc1_conversion_clock_out,
	output logic             bus_clock_pin_out,
	output logic             sdram_clock_pin_out,
	output logic             timer_hiz_out,
	output logic             irq_out
);

	// ****************************************
	// configuration registers
	// ****************************************
	logic [2:0]               adc0_clock_divider_select;
	logic [2:0]               adc1_clock_divider_select;
	cgc_pkg::cgc_src_type     sw_src;
	logic [4:0]               pin_cfg;
	logic [7:0]               main_osc_wait_select;
	logic [7:0]               sub_osc_wait_select;
	logic [3:0]               evt_status;
	logic [3:0]               evt_mask;
	logic                     forced;
	logic [7:0]               silence;
	logic                     stop_level;
	cgc_pkg::cgc_state_type   state;
	cgc_pkg::cgc_src_type     src_cur;
	cgc_pkg::cgc_src_type     src_tgt;
	logic [7:0]               stab_count;
	logic                     sys_clk;
	logic                     sys_half;

	// ****************************************
	// register decode
	// ****************************************
	wire wr_sys   = reg_wr_in && (reg_addr_in == cgc_pkg::OFS_SYS_CTRL);
	wire wr_pll   = reg_wr_in && (reg_addr_in == cgc_pkg::OFS_PLL_CTRL);
	wire wr_hs    = reg_wr_in && (reg_addr_in == cgc_pkg::OFS_HSOSC_CTRL);
	wire wr_pin   = reg_wr_in && (reg_addr_in == cgc_pkg::OFS_PIN_CTRL);
	wire wr_mwait = reg_wr_in && (reg_addr_in == cgc_pkg::OFS_MAIN_WAIT);
	wire wr_swait = reg_wr_in && (reg_addr_in == cgc_pkg::OFS_SUB_WAIT);
	wire wr_mask  = reg_wr_in && (reg_addr_in == cgc_pkg::OFS_MASK);
	wire rd_stat  = reg_rd_in && (reg_addr_in == cgc_pkg::OFS_STATUS);

	wire [2:0] w_src  = reg_wdata_in[cgc_pkg::SYS_SRC_LSB +: 3];
	wire [1:0] w_div  = reg_wdata_in[cgc_pkg::PLL_DIV_LSB +: 2];
	wire [5:0] w_mul  = reg_wdata_in[cgc_pkg::PLL_MUL_LSB +: 6];
	wire [1:0] w_freq = reg_wdata_in[cgc_pkg::HS_FREQ_LSB +: 2];
	wire src_ok  = (w_src <= 3'(cgc_pkg::SRC_PLL));
	wire div_ok  = (w_div <= cgc_pkg::DIV_BY_3);
	wire mul_ok  = (w_mul >= cgc_pkg::MULT_MIN) && (w_mul <= cgc_pkg::MULT_MAX);
	wire freq_ok = (w_freq <= cgc_pkg::HS_20MHZ);
	wire cfg_err = (wr_sys && !src_ok) || (wr_pll && !(div_ok && mul_ok))
	             || (wr_hs && !freq_ok);

	// tick of a given source
	function automatic logic src_tick(input cgc_pkg::cgc_src_type s);
		case (s)
			cgc_pkg::SRC_LOSC: src_tick = losc_tick_in;
			cgc_pkg::SRC_HOSC: src_tick = hosc_tick_in;
			cgc_pkg::SRC_MAIN: src_tick = main_tick_in;
			cgc_pkg::SRC_SUB:  src_tick = sub_tick_in;
			cgc_pkg::SRC_PLL:  src_tick = pll_tick_in;
			default:           src_tick = 1'b0;
		endcase
	endfunction

	// settle count a source needs before it is engaged
	function automatic logic [7:0] src_wait(input cgc_pkg::cgc_src_type s);
		case (s)
			cgc_pkg::SRC_MAIN: src_wait = main_osc_wait_select;
			cgc_pkg::SRC_SUB:  src_wait = sub_osc_wait_select;
			default:           src_wait = 8'h00;
		endcase
	endfunction

	// software configuration; illegal codes leave the old value
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			adc0_clock_divider_select <= cgc_pkg::RST_ADC;
			adc1_clock_divider_select <= cgc_pkg::RST_ADC;
			sw_src                    <= cgc_pkg::SRC_LOSC;
			pll_source_select_out     <= 1'b0;
			pll_prediv_out            <= cgc_pkg::DIV_BY_1;
			pll_mult_out              <= cgc_pkg::MULT_MIN;
			hosc_freq_out             <= cgc_pkg::HS_16MHZ;
			hosc_power_on_out         <= 1'b1;
			pin_cfg                   <= cgc_pkg::RST_PINS;
			main_osc_wait_select      <= cgc_pkg::RST_WAIT;
			sub_osc_wait_select       <= cgc_pkg::RST_WAIT;
			evt_mask                  <= 4'h0;
		end else begin
			if (wr_sys) begin
				adc0_clock_divider_select <= reg_wdata_in[cgc_pkg::SYS_ADC0_LSB +: 3];
				adc1_clock_divider_select <= reg_wdata_in[cgc_pkg::SYS_ADC1_LSB +: 3];
			end
			if (wr_sys && src_ok)
				sw_src <= cgc_pkg::cgc_src_type'(w_src);
			if (wr_pll && div_ok && mul_ok) begin
				pll_source_select_out <= reg_wdata_in[cgc_pkg::PLL_SRC_BIT];
				pll_prediv_out        <= w_div;
				pll_mult_out          <= w_mul;
			end
			if (wr_hs && freq_ok)
				hosc_freq_out <= w_freq;
			if (wr_hs)
				hosc_power_on_out <= ~reg_wdata_in[cgc_pkg::HS_STOP_BIT];
			if (wr_pin)
				pin_cfg <= reg_wdata_in[4:0];
			if (wr_mwait)
				main_osc_wait_select <= reg_wdata_in[7:0];
			if (wr_swait)
				sub_osc_wait_select <= reg_wdata_in[7:0];
			if (wr_mask)
				evt_mask <= reg_wdata_in[3:0];
		end
	end

	// ****************************************
	// stop detection and fallback
	// ****************************************
	wire det_en    = pin_cfg[cgc_pkg::PIN_DET_EN];
	wire stop_rise = det_en && !stop_level && (silence == cgc_pkg::STOP_LIMIT - 8'h01)
	               && !main_tick_in;
	wire release_w = wr_pin && reg_wdata_in[cgc_pkg::PIN_RELEASE];

	// silence counts cycles without a main tick
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			silence    <= 8'h00;
			stop_level <= 1'b0;
		end else if (main_tick_in || !det_en) begin
			silence    <= 8'h00;
			stop_level <= 1'b0;
		end else if (silence != cgc_pkg::STOP_LIMIT - 8'h01) begin
			silence    <= 8'(silence + 8'h01);
		end else begin
			stop_level <= 1'b1;
		end
	end

	// a new request wins over the software release
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			forced        <= 1'b0;
			evt_stop_out  <= 1'b0;
			timer_hiz_out <= 1'b0;
		end else begin
			evt_stop_out <= stop_rise;
			if (stop_rise || evt_switch_in)
				forced <= 1'b1;
			else if (release_w)
				forced <= 1'b0;
			if (stop_rise && pin_cfg[cgc_pkg::PIN_HIZ_EN])
				timer_hiz_out <= 1'b1;
			else if (release_w)
				timer_hiz_out <= 1'b0;
		end
	end

	// ****************************************
	// glitch-free source switch
	// ****************************************
	cgc_pkg::cgc_src_type src_req;
	assign src_req = forced ? cgc_pkg::SRC_LOSC : sw_src;
	wire cur_tick  = src_tick(src_cur);
	wire tgt_tick  = src_tick(src_tgt);
	wire engage    = (state == cgc_pkg::ST_WAIT) && (src_req == src_tgt) && tgt_tick
	               && (stab_count >= src_wait(src_tgt));
	// a stopped main source never ticks again, so its park is cut short
	wire cur_dead  = stop_level && (src_cur == cgc_pkg::SRC_MAIN);
	wire sys_tick  = ((state == cgc_pkg::ST_RUN) && cur_tick)
	               || ((state == cgc_pkg::ST_PARK) && (cur_tick || cur_dead) && sys_clk)
	               || engage;

	// the clock is parked low before the new source takes it up
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state      <= cgc_pkg::ST_RUN;
			src_cur    <= cgc_pkg::SRC_LOSC;
			src_tgt    <= cgc_pkg::SRC_LOSC;
			stab_count <= 8'h00;
		end else begin
			case (state)
				cgc_pkg::ST_RUN: begin
					if (src_req != src_cur) begin
						state   <= cgc_pkg::ST_PARK;
						src_tgt <= src_req;
					end
				end
				cgc_pkg::ST_PARK: begin
					stab_count <= 8'h00;
					if (!sys_clk || cur_tick || cur_dead)
						state <= cgc_pkg::ST_WAIT;
				end
				cgc_pkg::ST_WAIT: begin
					if (src_req != src_tgt) begin
						src_tgt    <= src_req;
						stab_count <= 8'h00;
					end else if (engage) begin
						src_cur <= src_tgt;
						state   <= cgc_pkg::ST_RUN;
					end else if (tgt_tick && stab_count != 8'hff) begin
						stab_count <= 8'(stab_count + 8'h01);
					end
				end
				default: state <= cgc_pkg::ST_RUN;
			endcase
		end
	end

	// system clock toggles once per accepted tick
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			sys_clk <= 1'b0;
		else if (sys_tick)
			sys_clk <= ~sys_clk;
	end

	// ****************************************
	// derived clocks and pins
	// ****************************************
	cgc_divider u_adc0 (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tick_in    (sys_tick),
		.sel_in     (adc0_clock_divider_select),
		.clk_out    (adc0_conversion_clock_out)
	);
	cgc_divider u_adc1 (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tick_in    (sys_tick),
		.sel_in     (adc1_clock_divider_select),
		.clk_out    (adc1_conversion_clock_out)
	);
	cgc_divider u_half (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tick_in    (sys_tick),
		.sel_in     (3'h1),
		.clk_out    (sys_half)
	);

	wire next_bus = pin_cfg[cgc_pkg::PIN_BUS_HIGH] ? 1'b1
	              : (pin_cfg[cgc_pkg::PIN_BUS_HALF] ? sys_half : sys_clk);
	wire next_sd  = pin_cfg[cgc_pkg::PIN_SD_HIGH] ? 1'b1 : sys_clk;

	// pin outputs retimed so every output leaves a flip-flop
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			system_clock_out    <= 1'b0;
			bus_clock_pin_out   <= 1'b1;
			sdram_clock_pin_out <= 1'b1;
		end else begin
			system_clock_out    <= sys_clk;
			bus_clock_pin_out   <= next_bus;
			sdram_clock_pin_out <= next_sd;
		end
	end

	// ****************************************
	// status, interrupt and read data
	// ****************************************
	wire [3:0] evt_set;
	assign evt_set[cgc_pkg::EVT_STOP]    = stop_rise;
	assign evt_set[cgc_pkg::EVT_LINK]    = evt_switch_in;
	assign evt_set[cgc_pkg::EVT_SWITCH]  = engage;
	assign evt_set[cgc_pkg::EVT_CFG_ERR] = cfg_err;

	wire [31:0] rd_mux =
		(reg_addr_in == cgc_pkg::OFS_SYS_CTRL)   ? {21'h0, 3'(sw_src), 1'b0,
		                                             adc1_clock_divider_select, 1'b0,
		                                             adc0_clock_divider_select} :
		(reg_addr_in == cgc_pkg::OFS_PLL_CTRL)   ? {18'h0, pll_mult_out, 3'h0,
		                                             pll_source_select_out, 2'h0,
		                                             pll_prediv_out} :
		(reg_addr_in == cgc_pkg::OFS_HSOSC_CTRL) ? {26'h0, hosc_freq_out, 3'h0,
		                                             ~hosc_power_on_out} :
		(reg_addr_in == cgc_pkg::OFS_PIN_CTRL)   ? {27'h0, pin_cfg} :
		(reg_addr_in == cgc_pkg::OFS_MAIN_WAIT)  ? {24'h0, main_osc_wait_select} :
		(reg_addr_in == cgc_pkg::OFS_SUB_WAIT)   ? {24'h0, sub_osc_wait_select} :
		(reg_addr_in == cgc_pkg::OFS_STATUS)     ? {28'h0, evt_status} :
		(reg_addr_in == cgc_pkg::OFS_MASK)       ? {28'h0, evt_mask} :
		(reg_addr_in == cgc_pkg::OFS_STATE)      ? {24'h0, timer_hiz_out, 2'(state),
		                                             stop_level, forced, 3'(src_cur)} :
		32'h0;

	// sticky bits: a set in the clearing read cycle survives
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			evt_status    <= 4'h0;
			reg_rdata_out <= 32'h0;
			irq_out       <= 1'b0;
		end else begin
			evt_status    <= (rd_stat ? 4'h0 : evt_status) | evt_set;
			reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
			irq_out       <= |(((rd_stat ? 4'h0 : evt_status) | evt_set) & evt_mask);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence s_stop_pulse;
		evt_stop_out ##1 !evt_stop_out;
	endsequence
	sequence s_park_to_wait;
		(state == cgc_pkg::ST_PARK) ##1 (state == cgc_pkg::ST_WAIT);
	endsequence

	property p_stop_fallback;
		@(posedge clk_sys_in) disable iff (srst_in)
		stop_rise |=> forced && (src_req == cgc_pkg::SRC_LOSC);
	endproperty
	a_stop_fallback: assert property (p_stop_fallback) else $error("no fallback on stop");

	property p_hiz;
		@(posedge clk_sys_in) disable iff (srst_in)
		stop_rise && pin_cfg[cgc_pkg::PIN_HIZ_EN] |=> timer_hiz_out;
	endproperty
	a_hiz: assert property (p_hiz) else $error("timer outputs not floated");

	property p_pll_src;
		@(posedge clk_sys_in) disable iff (srst_in)
		wr_pll && div_ok && mul_ok |=> pll_source_select_out == $past(reg_wdata_in[4]);
	endproperty
	a_pll_src: assert property (p_pll_src) else $error("pll source not taken");

	property p_prediv;
		@(posedge clk_sys_in) disable iff (srst_in)
		wr_pll && (w_div == 2'h3) |=> $stable(pll_prediv_out);
	endproperty
	a_prediv: assert property (p_prediv) else $error("illegal pre-divider taken");

	property p_mult;
		@(posedge clk_sys_in) disable iff (srst_in)
		(pll_mult_out >= 6'h0a) && (pll_mult_out <= 6'h1e);
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier out of range");

	property p_hs_freq;
		@(posedge clk_sys_in) disable iff (srst_in)
		wr_hs && !freq_ok |=> $stable(hosc_freq_out);
	endproperty
	a_hs_freq: assert property (p_hs_freq) else $error("illegal oscillator code");

	property p_bus_high;
		@(posedge clk_sys_in) disable iff (srst_in)
		pin_cfg[cgc_pkg::PIN_BUS_HIGH] ##1 pin_cfg[cgc_pkg::PIN_BUS_HIGH] |-> bus_clock_pin_out;
	endproperty
	a_bus_high: assert property (p_bus_high) else $error("bus pin not high");

	property p_sd_follow;
		@(posedge clk_sys_in) disable iff (srst_in)
		!pin_cfg[cgc_pkg::PIN_SD_HIGH] |=> sdram_clock_pin_out == $past(sys_clk);
	endproperty
	a_sd_follow: assert property (p_sd_follow) else $error("sdram pin wrong");

	property p_stop_evt;
		@(posedge clk_sys_in) disable iff (srst_in)
		stop_rise |=> s_stop_pulse;
	endproperty
	a_stop_evt: assert property (p_stop_evt) else $error("stop event not one pulse");

	property p_link;
		@(posedge clk_sys_in) disable iff (srst_in)
		evt_switch_in |=> forced;
	endproperty
	a_link: assert property (p_link) else $error("link request ignored");

	property p_no_runt;
		@(posedge clk_sys_in) disable iff (srst_in)
		s_park_to_wait |-> !sys_clk ##1 (!sys_clk || $past(engage));
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("clock not parked low");

endmodule

/* File: core/cgc_divider.sv */
`timescale 1ns/100ps
module cgc_divider (
	// clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       srst_in,
	// one tick per source half period
	input  wire logic       tick_in,
	input  wire logic [2:0] sel_in,
	// divided clock
	output logic            clk_out
);

	logic [6:0] count;
	wire  [6:0] last_count = 7'((8'h01 << sel_in) - 8'h01);
	wire        wrap       = tick_in && (count >= last_count);

	// output half period is two to the power of sel ticks
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			count   <= 7'h00;
			clk_out <= 1'b0;
		end else if (wrap) begin
			count   <= 7'h00;
			clk_out <= ~clk_out;
		end else if (tick_in) begin
			count   <= 7'(count + 7'h01);
		end
	end

endmodule

/* File: core/cgc_pkg.sv */
package cgc_pkg;

	// ****************************************
	// bus and register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_SYS_CTRL   = 8'h00; // system_clock_control
	localparam logic [7:0] OFS_PLL_CTRL   = 8'h04;
	localparam logic [7:0] OFS_HSOSC_CTRL = 8'h08;
	localparam logic [7:0] OFS_PIN_CTRL   = 8'h0c;
	localparam logic [7:0] OFS_MAIN_WAIT  = 8'h10; // main_osc_wait_control
	localparam logic [7:0] OFS_SUB_WAIT   = 8'h14; // sub_osc_wait_control
	localparam logic [7:0] OFS_STATUS     = 8'h18;
	localparam logic [7:0] OFS_MASK       = 8'h1c;
	localparam logic [7:0] OFS_STATE      = 8'h20;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SYS_ADC0_LSB  = 0;  // adc0_clock_divider_select, 3 bits
	localparam int SYS_ADC1_LSB  = 4;  // adc1_clock_divider_select, 3 bits
	localparam int SYS_SRC_LSB   = 8;  // clock source, 3 bits
	localparam int PLL_DIV_LSB   = 0;  // pre-divider code, 2 bits
	localparam int PLL_SRC_BIT   = 4;  // pll_source_select
	localparam int PLL_MUL_LSB   = 8;  // multiplier, 6 bits
	localparam int HS_STOP_BIT   = 0;  // oscillator power off
	localparam int HS_FREQ_LSB   = 4;  // frequency code, 2 bits
	localparam int PIN_BUS_HIGH  = 0;
	localparam int PIN_BUS_HALF  = 1;
	localparam int PIN_SD_HIGH   = 2;
	localparam int PIN_DET_EN    = 3;
	localparam int PIN_HIZ_EN    = 4;
	localparam int PIN_RELEASE   = 7;  // write one: leave the forced fallback
	localparam int WAIT_W        = 8;
	localparam int NUM_EVT       = 4;
	localparam int EVT_STOP      = 0;
	localparam int EVT_LINK      = 1;
	localparam int EVT_SWITCH    = 2;
	localparam int EVT_CFG_ERR   = 3;

	// ****************************************
	// legal settings and reset values
	// ****************************************
	localparam logic [1:0] DIV_BY_1  = 2'h0;
	localparam logic [1:0] DIV_BY_3  = 2'h2; // last legal pre-divider code
	localparam logic [5:0] MULT_MIN  = 6'h0a;
	localparam logic [5:0] MULT_MAX  = 6'h1e;
	localparam logic [1:0] HS_16MHZ  = 2'h0;
	localparam logic [1:0] HS_20MHZ  = 2'h2; // 2'h1 selects 18 MHz
	localparam logic [2:0] RST_ADC   = 3'h0;
	localparam logic [7:0] RST_WAIT  = 8'hff;
	localparam logic [4:0] RST_PINS  = 5'h1d; // pins high, detect and hiz on

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 100;
	localparam int STOP_TIME_NS    = 5000; // silence that counts as a stop
	localparam int STOP_CYCLES     = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] STOP_LIMIT = 8'(STOP_CYCLES);

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		SRC_LOSC = 3'h0, // low_speed_onchip_osc
		SRC_HOSC = 3'h1, // high_speed_onchip_osc
		SRC_MAIN = 3'h2,
		SRC_SUB  = 3'h3,
		SRC_PLL  = 3'h4
	} cgc_src_type;

	typedef enum logic [1:0] {
		ST_RUN  = 2'h0,
		ST_PARK = 2'h1,
		ST_WAIT = 2'h3
	} cgc_state_type;

endpackage

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic        clk_sys_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        losc_tick_in = 1'b0;
	logic        hosc_tick_in = 1'b0;
	logic        main_tick_in = 1'b0;
	logic        sub_tick_in = 1'b0;
	logic        pll_tick_in = 1'b0;
	logic        evt_switch_in = 1'b0;
	logic        main_run = 1'b1;
	logic [3:0]  tcnt = 4'h0;
	logic [31:0] rdata_out, d;
	logic        evt_out, psel, hpwr, sclk, a0, a1, bpin, spin, hiz, irq;
	logic [1:0]  pdiv, hfreq;
	logic [5:0]  pmul;
	int          fail_count = 0;
	int          checks = 0;

	cgc_core cgc_core_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(rdata_out), .losc_tick_in(losc_tick_in),
		.hosc_tick_in(hosc_tick_in), .main_tick_in(main_tick_in), .sub_tick_in(sub_tick_in),
		.pll_tick_in(pll_tick_in), .evt_switch_in(evt_switch_in), .evt_stop_out(evt_out),
		.pll_source_select_out(psel), .pll_prediv_out(pdiv), .pll_mult_out(pmul),
		.hosc_freq_out(hfreq), .hosc_power_on_out(hpwr), .system_clock_out(sclk),
		.adc0_conversion_clock_out(a0), .adc1_conversion_clock_out(a1),
		.bus_clock_pin_out(bpin), .sdram_clock_pin_out(spin), .timer_hiz_out(hiz),
		.irq_out(irq));

	// clock and oscillator tick patterns
	always #50 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		tcnt <= tcnt + 4'h1;
		losc_tick_in <= (tcnt[1:0] == 2'h0);
		hosc_tick_in <= tcnt[0];
		main_tick_in <= main_run & tcnt[0];
		sub_tick_in <= (tcnt == 4'h0);
		pll_tick_in <= ~pll_tick_in;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("unexpected %s: expected %h, seen %h", n, e, g);
			fail_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask

	// polls the state register until the current source matches
	task automatic wait_src(input logic [2:0] s);
		for (int i = 0; i < 200; i++) begin
			rd(cgc_pkg::OFS_STATE, d);
			if (d[2:0] === s) break;
		end
	endtask

	// counts toggles of the system clock, both pins and both adc clocks over a window
	task automatic count_pins(output int st, output int bt, output int pt, output int at0,
		output int at1);
		logic s0, b0, p0, c0, c1;
		st = 0;
		bt = 0;
		pt = 0;
		at0 = 0;
		at1 = 0;
		for (int i = 0; i < 80; i++) begin
			s0 = sclk;
			b0 = bpin;
			p0 = spin;
			c0 = a0;
			c1 = a1;
			@(posedge clk_sys_in);
			#1;
			st += int'(s0 !== sclk);
			bt += int'(b0 !== bpin);
			pt += int'(p0 !== spin);
			at0 += int'(c0 !== a0);
			at1 += int'(c1 !== a1);
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		chk("pll mult", 32'd10, {26'h0, pmul});
		chk("pll div", 32'h0, {30'h0, pdiv});
		chk("hosc power", 32'h1, {31'h0, hpwr});
		chk("pins", 32'h3, {30'h0, bpin, spin});
		rd(cgc_pkg::OFS_PIN_CTRL, d);
		chk("pin ctrl", 32'h1d, d);
		rd(cgc_pkg::OFS_MAIN_WAIT, d);
		chk("main wait", 32'hff, d);
		rd(cgc_pkg::OFS_SUB_WAIT, d);
		chk("sub wait", 32'hff, d);
		rd(8'h40, d);
		chk("unmapped", 32'h0, d);
	endtask

	task automatic t_pll;
		wr(cgc_pkg::OFS_PLL_CTRL, 32'h1e12);
		chk("pll src", 32'h1, {31'h0, psel});
		chk("pll div", 32'h2, {30'h0, pdiv});
		chk("pll mult", 32'd30, {26'h0, pmul});
		wr(cgc_pkg::OFS_PLL_CTRL, 32'h1f12);
		chk("pll mult kept", 32'd30, {26'h0, pmul});
		rd(cgc_pkg::OFS_STATUS, d);
		chk("cfg err", 32'h8, d & 32'h8);
		wr(cgc_pkg::OFS_PLL_CTRL, 32'h1e13);
		chk("pll div kept", 32'h2, {30'h0, pdiv});
		wr(cgc_pkg::OFS_PLL_CTRL, 32'h0a01);
		chk("pll src main", 32'h0, {31'h0, psel});
		chk("pll div 2", 32'h1, {30'h0, pdiv});
		chk("pll mult 10", 32'd10, {26'h0, pmul});
		rd(cgc_pkg::OFS_STATUS, d);
	endtask

	task automatic t_hosc_waits;
		for (int f = 0; f < 3; f++) begin
			wr(cgc_pkg::OFS_HSOSC_CTRL, 32'(f) << 4);
			chk("hosc freq", 32'(f), {30'h0, hfreq});
		end
		wr(cgc_pkg::OFS_HSOSC_CTRL, 32'h1);
		chk("hosc off", 32'h0, {31'h0, hpwr});
		wr(cgc_pkg::OFS_HSOSC_CTRL, 32'h0);
		wr(cgc_pkg::OFS_HSOSC_CTRL, 32'h30);
		chk("hosc freq kept", 32'h0, {30'h0, hfreq});
		wr(cgc_pkg::OFS_MAIN_WAIT, 32'h12345678);
		rd(cgc_pkg::OFS_MAIN_WAIT, d);
		chk("main wait", 32'h78, d);
		wr(cgc_pkg::OFS_SUB_WAIT, 32'habcdef5a);
		rd(cgc_pkg::OFS_SUB_WAIT, d);
		chk("sub wait", 32'h5a, d);
	endtask

	task automatic t_pins;
		int st, bt, pt, at0, at1;
		wr(cgc_pkg::OFS_SYS_CTRL, 32'h10);
		wr(cgc_pkg::OFS_PIN_CTRL, 32'h18);
		count_pins(st, bt, pt, at0, at1);
		chk("bus full", 32'h1, 32'(bt > st / 2 + 1));
		chk("sdram runs", 32'h1, 32'(pt > 0));
		chk("adc0 full", 32'h1, 32'(at0 > st / 2 + 1));
		chk("adc1 half", 32'h1, 32'(at1 > 0 && at1 <= st / 2 + 1));
		wr(cgc_pkg::OFS_PIN_CTRL, 32'h1a);
		count_pins(st, bt, pt, at0, at1);
		chk("bus half", 32'h1, 32'(bt > 0 && bt <= st / 2 + 1));
		wr(cgc_pkg::OFS_PIN_CTRL, 32'h1d);
		count_pins(st, bt, pt, at0, at1);
		chk("pins high", 32'h3, {30'h0, bpin, spin});
		chk("pins still", 32'h0, 32'(bt + pt));
	endtask

	task automatic t_switch;
		rd(cgc_pkg::OFS_STATUS, d);
		wr(cgc_pkg::OFS_SYS_CTRL, 32'h100);
		wait_src(3'h1);
		chk("sw source", 32'h1, {29'h0, d[2:0]});
		@(posedge clk_sys_in);
		evt_switch_in <= 1'b1;
		@(posedge clk_sys_in);
		evt_switch_in <= 1'b0;
		wait_src(3'h0);
		chk("link source", 32'h8, d & 32'hf);
		rd(cgc_pkg::OFS_STATUS, d);
		chk("link status", 32'h6, d & 32'h6);
	endtask

	task automatic t_stop;
		int seen;
		wr(cgc_pkg::OFS_MASK, 32'h1);
		wr(cgc_pkg::OFS_PIN_CTRL, 32'h9d);
		wr(cgc_pkg::OFS_SYS_CTRL, 32'h200);
		wait_src(3'h2);
		chk("main source", 32'h2, {29'h0, d[2:0]});
		rd(cgc_pkg::OFS_STATUS, d);
		main_run = 1'b0;
		seen = 0;
		for (int i = 0; i < 150 && seen == 0; i++) begin
			@(posedge clk_sys_in);
			#1 seen = int'(evt_out === 1'b1);
		end
		chk("stop event", 32'h1, 32'(seen));
		@(posedge clk_sys_in);
		#1 chk("stop pulse", 32'h0, {31'h0, evt_out});
		chk("timer hiz", 32'h1, {31'h0, hiz});
		chk("irq", 32'h1, {31'h0, irq});
		wait_src(3'h0);
		chk("stop source", 32'h88, d & 32'h8f);
		rd(cgc_pkg::OFS_STATUS, d);
		chk("stop status", 32'h1, d & 32'h1);
		repeat (2) @(posedge clk_sys_in);
		#1 chk("irq cleared", 32'h0, {31'h0, irq});
		wr(cgc_pkg::OFS_PIN_CTRL, 32'h9d);
		chk("hiz released", 32'h0, {31'h0, hiz});
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		t_reset();
		t_pll();
		t_hosc_waits();
		t_pins();
		t_switch();
		t_stop();
		print_verdict();
	end

	// watchdog, well beyond the several hundred cycles the scenarios need
	initial begin
		#(30000 * 100);
		fail_count++;
		print_verdict();
	end
endmodule
